// File: logic/io_scan_scheduler.sv
// scan scheduler of the bus controller: slot config, consumption, production, trigger
// assumes slot starts and item streams come from network logic on clk_sys
`timescale 1ns/1ps
`include "fieldbus_cfg.svh"
module io_scan_scheduler #(
  parameter int MS_CYC   = `MS_CYC,
  parameter int CONS_CYC = `CONS_DELAY_CYC,
  parameter int PROD_CYC = `PROD_DELAY_CYC
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // slot configuration
  input  wire logic               cfgWe,
  input  wire logic [`SLOT_W-1:0] cfgSlot,
  input  wire logic [`SET_W-1:0]  cfgScanSet,
  input  wire logic [`SYNC_W-1:0] cfgSyncSet,
  input  wire logic               cfgSync,
  input  wire logic               cfgSource,
  input  wire logic               cfgOutput,
  input  wire logic               cfgHold,
  input  wire logic [`ADDR_W-1:0] cfgBase,
  input  wire logic [7:0]         cfgCount,
  input  wire logic [7:0]         cfgPeriodMs,
  input  wire logic [7:0]         refreshCoef,
  input  wire logic [7:0]         refreshOffset,
  // host side
  input  wire logic               hostWe,
  input  wire logic [`ADDR_W-1:0] hostAddr,
  input  wire logic [`ITEM_W-1:0] hostWdata,
  output logic      [`ITEM_W-1:0] hostRdata,
  input  wire logic               hostOutScan,
  input  wire logic [`SET_W-1:0]  hostOutSet,
  output logic                    syncTrigger,
  output logic      [`SYNC_W-1:0] syncTriggerSet,
  // network slot timing
  input  wire logic               slotStart,
  input  wire logic [`SLOT_W-1:0] slotIdx,
  // consumed items
  input  wire logic               netRxValid,
  output logic                    netRxReady,
  input  wire logic [`ITEM_W-1:0] netRxData,
  input  wire logic               netRxValidator,
  input  wire logic               netRxOk,
  // produced items
  output logic                    netTxValid,
  input  wire logic               netTxReady,
  output logic      [`ITEM_W-1:0] netTxData,
  output logic                    netTxFresh,
  // status
  output logic                    busy,
  output logic      [`NSLOT-1:0]  outSignificant,
  output logic      [`NSLOT-1:0]  outRefreshed
);
  fieldbus_pkg::sched_t s;
  fieldbus_pkg::sched_t next_s;
  shared_mem_if memB ();

  shared_item_mem u_mem (
    .clk_sys   (clk_sys),
    .hostWe    (hostWe),
    .hostAddr  (hostAddr),
    .hostWdata (hostWdata),
    .hostRdata (hostRdata),
    .ctl       (memB.mem)
  );

  // a sync set number of zero means the slot is not synchronous
  function automatic logic isSync(input logic syncBit, input logic [`SYNC_W-1:0] setNo);
    return syncBit && (setNo != 4'h0);
  endfunction

  function automatic logic [`ADDR_W-1:0] itemAddr(input logic [`ADDR_W-1:0] base,
                                                  input logic [7:0] idx);
    return `ADDR_W'(base + idx);
  endfunction

  // refresh period in ms; saturates rather than wraps
  function automatic logic [15:0] refreshLimit(input logic [7:0] coef, input logic [7:0] per,
                                               input logic [7:0] offs);
    logic [16:0] sum;
    // widen before the product so it is not cut to eight bits
    sum = 17'(coef) * 17'(per) + 17'(offs);
    return sum[16] ? 16'hffff : sum[15:0];
  endfunction

  function automatic fieldbus_pkg::sched_t resetState();
    fieldbus_pkg::sched_t r;
    r = '0;
    r.state = fieldbus_pkg::ST_IDLE;
    for (int i = 0; i < `NSLOT; i++) begin
      r.set[i] = `DEFAULT_SET;
    end
    return r;
  endfunction

  logic [`SLOT_W-1:0] sl;
  assign sl = s.slot;

  always_comb begin
    next_s = s;
    next_s.trig = 1'b0;
    next_s.msTick = 1'b0;
    memB.en = 1'b0;
    memB.we = 1'b0;
    memB.mask = '0;
    memB.wdata = '0;
    memB.addr = itemAddr(s.base[sl], s.idx);
    netRxReady = (s.state == fieldbus_pkg::ST_CONS) && (s.idx != s.cnt[sl]);

    // millisecond enable for refresh aging
    if (s.msDiv == 14'(MS_CYC - 1)) begin
      next_s.msDiv = '0;
      next_s.msTick = 1'b1;
    end else begin
      next_s.msDiv = s.msDiv + 14'h1;
    end

    // outputs age between host scans and drop to unrefreshed at the limit
    for (int i = 0; i < `NSLOT; i++) begin
      if (s.msTick && s.isOut[i] && s.fresh[i]) begin
        if (s.age[i] >= refreshLimit(refreshCoef, s.period[i], refreshOffset)) begin
          next_s.fresh[i] = 1'b0;
        end else begin
          next_s.age[i] = s.age[i] + 16'h1;
        end
      end
    end

    // one set field per slot keeps the slot in exactly one scan set
    if (cfgWe) begin
      next_s.set[cfgSlot] = cfgScanSet;
      next_s.syncSet[cfgSlot] = cfgSyncSet;
      next_s.sync[cfgSlot] = cfgSync;
      next_s.src[cfgSlot] = cfgSource;
      next_s.isOut[cfgSlot] = cfgOutput;
      next_s.hold[cfgSlot] = cfgHold;
      next_s.base[cfgSlot] = cfgBase;
      next_s.cnt[cfgSlot] = cfgCount;
      // one period per slot; the slots of one sync set are all written with the same one
      next_s.period[cfgSlot] = cfgPeriodMs;
      next_s.signif[cfgSlot] = 1'b0;
      next_s.newData[cfgSlot] = 1'b0;
      next_s.fresh[cfgSlot] = 1'b0;
    end

    case (s.state)
      fieldbus_pkg::ST_IDLE: begin
        // a slot start while busy is dropped; the next occurrence is taken instead
        if (slotStart) begin
          next_s.slot = slotIdx;
          next_s.idx = '0;
          if (s.isOut[slotIdx]) begin
            if (isSync(s.sync[slotIdx], s.syncSet[slotIdx])) begin
              next_s.delay = 16'(PROD_CYC - 1);
              next_s.state = fieldbus_pkg::ST_DLY;
            end else if (s.newData[slotIdx]) begin
              next_s.newData[slotIdx] = 1'b0;
              next_s.state = fieldbus_pkg::ST_PREAD;
            end
          end else if (isSync(s.sync[slotIdx], s.syncSet[slotIdx])) begin
            next_s.delay = 16'(CONS_CYC - 1);
            next_s.state = fieldbus_pkg::ST_DLY;
          end else begin
            next_s.state = fieldbus_pkg::ST_CONS;
          end
        end
      end
      fieldbus_pkg::ST_DLY: begin
        if (s.delay == 16'h0) begin
          // output delay runs from its own slot start, which follows the input slot
          next_s.state = s.isOut[sl] ? fieldbus_pkg::ST_PREAD : fieldbus_pkg::ST_CONS;
        end else begin
          next_s.delay = s.delay - 16'h1;
        end
      end
      fieldbus_pkg::ST_CONS: begin
        if (s.idx == s.cnt[sl]) begin
          next_s.state = fieldbus_pkg::ST_IDLE;
          if (isSync(s.sync[sl], s.syncSet[sl]) && s.src[sl]) begin
            next_s.trig = 1'b1;
            next_s.trigSet = s.syncSet[sl];
          end
        end else if (netRxValid) begin
          memB.en = 1'b1;
          memB.we = 1'b1;
          memB.mask = '1;
          memB.wdata = netRxData;
          if (!netRxOk) begin
            if (netRxValidator) begin
              memB.mask = `VAL_FAULT_MASK;
              memB.wdata = `VAL_FAULT_MASK;
            end else if (s.hold[sl]) begin
              memB.we = 1'b0;
            end else begin
              memB.wdata = '0;
            end
          end
          next_s.idx = s.idx + 8'h1;
        end
      end
      fieldbus_pkg::ST_PREAD: begin
        if (s.idx == s.cnt[sl]) begin
          next_s.state = fieldbus_pkg::ST_IDLE;
        end else begin
          memB.en = 1'b1;
          next_s.txValid = 1'b1;
          next_s.state = fieldbus_pkg::ST_PSEND;
        end
      end
      fieldbus_pkg::ST_PSEND: begin
        if (netTxReady) begin
          next_s.txValid = 1'b0;
          next_s.idx = s.idx + 8'h1;
          next_s.state = fieldbus_pkg::ST_PREAD;
        end
      end
      default: begin
        next_s.state = fieldbus_pkg::ST_IDLE;
      end
    endcase

    // host output scan comes last so it wins over a same-cycle clear
    if (hostOutScan) begin
      for (int i = 0; i < `NSLOT; i++) begin
        if (s.isOut[i] && (s.set[i] == hostOutSet)) begin
          next_s.signif[i] = 1'b1;
          next_s.newData[i] = 1'b1;
          next_s.fresh[i] = 1'b1;
          next_s.age[i] = '0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s <= resetState();
    end else begin
      s <= next_s;
    end
  end

  assign syncTrigger = s.trig;
  assign syncTriggerSet = s.trigSet;
  assign netTxValid = s.txValid;
  assign netTxData = memB.rdata;
  assign netTxFresh = s.signif[sl] && s.fresh[sl];
  assign busy = (s.state != fieldbus_pkg::ST_IDLE);
  assign outSignificant = s.signif;
  assign outRefreshed = s.fresh;
endmodule // io_scan_scheduler

// File: inc/fieldbus_cfg.svh
// constants of the fieldbus i/o scan scheduler: sizes, bits, reset values, timing
// assumes a 10 MHz clk_sys; times are kept in their own unit and turned into cycles here
// Notes on behaviour
// - async inputs are taken at each slot occurrence, not aligned to production instant
// - async inputs keep being scanned and latest values stay in shared memory
// - async outputs refresh only after host output scan of the slot's scan set
// - outputs stay not-significant until the first host output scan
// - outputs go unrefreshed once refresh period (coefficient, offset) runs out
// - after reset every slot is in scan set 0, asynchronous, no output delay
// - up to 32 asynchronous scan sets, each with own period and delay; here the period is set per slot and async slots get no delay
// - each slot maps to exactly one scan set; a set holds any number
// - at most 15 synchronous scan sets, each able to trigger the host
// - trigger only after all inputs and validators of the sync set are taken; here it fires at the end of each sync source input slot's own items
// - sync outputs wait a fixed 3 ms before production
// - consumption splits comm variables into items in shared memory
// - production gathers items from shared memory into comm variables onto network
// - sync input slot sits just before the output slot in phase
// - all slots of one sync scan set share one period
// - exactly one controller is sync source and issues the trigger
// - output slots outside a sync set use asynchronous refresh
// - failed data item becomes zero or holds last value, as configured
// - failed validator sets only its point-fault bit
// - new host output data is copied and produced onto the network
`ifndef FIELDBUS_CFG_SVH
`define FIELDBUS_CFG_SVH

`define NSLOT            8
`define SLOT_W           3
`define ITEM_W           16
`define ADDR_W           8
`define MEM_DEPTH        256
`define SET_W            5
`define SYNC_W           4
`define DEFAULT_SET      5'h00
`define VAL_FAULT_MASK   16'h0001
`define CLK_PERIOD_NS    100
`define MS_NS            1000000
`define CONS_DELAY_MS    1
`define PROD_DELAY_MS    3
`define MS_CYC           (`MS_NS / `CLK_PERIOD_NS)
`define CONS_DELAY_CYC   (`CONS_DELAY_MS * `MS_NS / `CLK_PERIOD_NS)
`define PROD_DELAY_CYC   (`PROD_DELAY_MS * `MS_NS / `CLK_PERIOD_NS)

`endif

// File: inc/fieldbus_pkg.sv
// types of the fieldbus i/o scan scheduler
// assumes fieldbus_cfg.svh on the include path
`include "fieldbus_cfg.svh"
package fieldbus_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DLY   = 3'b001,
    ST_CONS  = 3'b010,
    ST_PREAD = 3'b011,
    ST_PSEND = 3'b100
  } state_t;

  typedef struct packed {
    state_t                                state;
    logic [15:0]                           delay;
    logic [`SLOT_W-1:0]                    slot;
    logic [7:0]                            idx;
    logic [13:0]                           msDiv;
    logic                                  msTick;
    logic                                  trig;
    logic [`SYNC_W-1:0]                    trigSet;
    logic                                  txValid;
    logic [`NSLOT-1:0][`SET_W-1:0]         set;
    logic [`NSLOT-1:0][`SYNC_W-1:0]        syncSet;
    logic [`NSLOT-1:0]                     sync;
    logic [`NSLOT-1:0]                     src;
    logic [`NSLOT-1:0]                     isOut;
    logic [`NSLOT-1:0]                     hold;
    logic [`NSLOT-1:0]                     signif;
    logic [`NSLOT-1:0]                     newData;
    logic [`NSLOT-1:0]                     fresh;
    logic [`NSLOT-1:0][`ADDR_W-1:0]        base;
    logic [`NSLOT-1:0][7:0]                cnt;
    logic [`NSLOT-1:0][7:0]                period;
    logic [`NSLOT-1:0][15:0]               age;
  } sched_t;
endpackage

// File: inc/shared_mem_if.sv
// controller-side port of the shared item memory
// assumes one clock; read data arrive one cycle after an enabled read
`timescale 1ns/1ps
`include "fieldbus_cfg.svh"
interface shared_mem_if;
  logic              en;
  logic              we;
  logic [`ADDR_W-1:0] addr;
  logic [`ITEM_W-1:0] mask;
  logic [`ITEM_W-1:0] wdata;
  logic [`ITEM_W-1:0] rdata;
  modport ctl (output en, output we, output addr, output mask, output wdata, input rdata);
  modport mem (input en, input we, input addr, input mask, input wdata, output rdata);
endinterface

// File: logic/shared_item_mem.sv
// dual-port item memory shared by host scans and the scheduler
// assumes both ports on clk_sys; read data registered
`timescale 1ns/1ps
`include "fieldbus_cfg.svh"
module shared_item_mem (
  // clock
  input  wire logic               clk_sys,
  // host port
  input  wire logic               hostWe,
  input  wire logic [`ADDR_W-1:0] hostAddr,
  input  wire logic [`ITEM_W-1:0] hostWdata,
  output logic      [`ITEM_W-1:0] hostRdata,
  // controller port
  shared_mem_if.mem               ctl
);
  logic [`ITEM_W-1:0] store [0:`MEM_DEPTH-1];

  // bit mask lets a failed validator touch only its fault bit; controller write wins on a clash
  always_ff @(posedge clk_sys) begin
    if (hostWe) begin
      store[hostAddr] <= hostWdata;
    end
    if (ctl.en && ctl.we) begin
      store[ctl.addr] <= (store[ctl.addr] & ~ctl.mask) | (ctl.wdata & ctl.mask);
    end
    hostRdata <= store[hostAddr];
    if (ctl.en) begin
      ctl.rdata <= store[ctl.addr];
    end
  end
endmodule // shared_item_mem

// File: verification/sched_chk.sv
// port assertions of the scan scheduler
// assumes binding into io_scan_scheduler, one clock, sync active-low reset
`timescale 1ns/1ps
`include "fieldbus_cfg.svh"
module sched_chk #(
  parameter int MS_CYC   = 20,
  parameter int CONS_CYC = 20,
  parameter int PROD_CYC = 60
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_n,
  // watched ports
  input wire logic              busy,
  input wire logic              netRxReady,
  input wire logic              netTxValid,
  input wire logic              netTxReady,
  input wire logic [15:0]       netTxData,
  input wire logic              syncTrigger,
  input wire logic              hostOutScan,
  input wire logic [`NSLOT-1:0] outSignificant,
  input wire logic [`NSLOT-1:0] outRefreshed
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_ready_when_idle: assert property (!busy |-> !netRxReady) else $error("ready while idle");
  a_tx_held_stall: assert property (netTxValid && !netTxReady |=> netTxValid && $stable(netTxData))
    else $error("tx item dropped during stall");
  a_tx_needs_busy: assert property (netTxValid |-> busy) else $error("tx valid while idle");
  a_trig_one_cycle: assert property (syncTrigger |=> !syncTrigger) else $error("trigger too long");
  a_trig_at_end: assert property (syncTrigger |-> !busy && $past(busy)) else $error("trigger off end");
  a_signif_by_scan: assert property ((outSignificant & ~$past(outSignificant)) != '0 |-> $past(hostOutScan))
    else $error("significant without scan");
  a_fresh_by_scan: assert property ((outRefreshed & ~$past(outRefreshed)) != '0 |-> $past(hostOutScan))
    else $error("refreshed without scan");
  a_fresh_in_signif: assert property ((outRefreshed & ~outSignificant) == '0) else $error("fresh not signif");
  a_reset_clears: assert property (!$past(rst_n) |-> outSignificant == '0 && !syncTrigger && !netTxValid)
    else $error("flags not cleared by reset");

  c_trigger: cover property (syncTrigger);
  c_tx_taken: cover property (netTxValid && netTxReady);
  c_unrefreshed: cover property (outSignificant != outRefreshed);
endmodule // sched_chk

bind io_scan_scheduler sched_chk #(.MS_CYC(MS_CYC), .CONS_CYC(CONS_CYC), .PROD_CYC(PROD_CYC)) u_chk (
  .clk_sys, .rst_n, .busy, .netRxReady, .netTxValid, .netTxReady, .netTxData, .syncTrigger,
  .hostOutScan, .outSignificant, .outRefreshed);

// File: verification/host_scan_model.sv
// host side: output scans on trigger or on bench request
// assumes trigger set n maps to scan set code n; memory traffic is left to the bench
`timescale 1ns/1ps
`include "fieldbus_cfg.svh"
module host_scan_model (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // controller trigger
  input wire logic               syncTrigger,
  input wire logic [`SYNC_W-1:0] syncTriggerSet,
  // bench request for an async output scan
  input wire logic               scanReq,
  input wire logic [`SET_W-1:0]  scanReqSet,
  // scan report
  output logic                   hostOutScan,
  output logic [`SET_W-1:0]      hostOutSet
);
  // short logic run, far inside the production delay so outputs are ready in time
  logic [2:0]        runDly;
  logic [`SET_W-1:0] pendSet;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {runDly, pendSet, hostOutScan, hostOutSet} <= '0;
    end else begin
      hostOutScan <= 1'h0;
      runDly      <= {runDly[1:0], syncTrigger};
      if (syncTrigger) begin
        pendSet <= {1'h0, syncTriggerSet};
      end
      if (runDly[2]) begin
        hostOutScan <= 1'h1;
        hostOutSet  <= pendSet;
      end else if (scanReq) begin
        hostOutScan <= 1'h1;
        hostOutSet  <= scanReqSet;
      end
    end
  end
endmodule // host_scan_model

// File: verification/io_scan_scheduler_bench.sv
// self-checking bench of io_scan_scheduler with short ms and delay counts
// assumes host_scan_model and sched_chk compiled first
`timescale 1ns/1ps
`include "fieldbus_cfg.svh"
module io_scan_scheduler_bench;
  localparam int MS = 20, CONS = 20, PROD = 60;
  logic        clk_sys = 1'h0, rst_n = 1'h0;
  logic        cfgWe, cfgSync, cfgSource, cfgOutput, cfgHold, hostWe, scanReq, slotStart;
  logic        netRxValid, netRxValidator, netRxOk, netTxReady;
  logic        netRxReady, netTxValid, netTxFresh, busy, syncTrigger, hostOutScan;
  logic [2:0]  cfgSlot, slotIdx;
  logic [4:0]  cfgScanSet, scanReqSet, hostOutSet;
  logic [3:0]  cfgSyncSet, syncTriggerSet;
  logic [7:0]  cfgBase, cfgCount, cfgPeriodMs, refreshCoef, refreshOffset, hostAddr, outSignificant, outRefreshed;
  logic [15:0] hostWdata, hostRdata, netRxData, netTxData, d;
  int          fails = 0, checked = 0, n;

  io_scan_scheduler #(.MS_CYC(MS), .CONS_CYC(CONS), .PROD_CYC(PROD)) dut (.clk_sys, .rst_n, .cfgWe, .cfgSlot,
    .cfgScanSet, .cfgSyncSet, .cfgSync, .cfgSource, .cfgOutput, .cfgHold, .cfgBase, .cfgCount, .cfgPeriodMs,
    .refreshCoef, .refreshOffset, .hostWe, .hostAddr, .hostWdata, .hostRdata, .hostOutScan, .hostOutSet,
    .syncTrigger, .syncTriggerSet, .slotStart, .slotIdx, .netRxValid, .netRxReady, .netRxData, .netRxValidator,
    .netRxOk, .netTxValid, .netTxReady, .netTxData, .netTxFresh, .busy, .outSignificant, .outRefreshed);
  host_scan_model host (.clk_sys, .rst_n, .syncTrigger, .syncTriggerSet, .scanReq, .scanReqSet, .hostOutScan,
    .hostOutSet);

  always #50 clk_sys = ~clk_sys;

  task automatic step(input int k = 1);
    repeat (k) @(posedge clk_sys);
    #10;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg(input logic [2:0] s, input logic [4:0] ss, input logic [3:0] sy, input logic o, h,
                     input logic [7:0] b, c);
    {cfgSlot, cfgScanSet, cfgSyncSet, cfgOutput, cfgHold, cfgBase, cfgCount} = {s, ss, sy, o, h, b, c};
    {cfgSync, cfgSource} = {2{sy != 4'h0}};
    cfgWe = 1'h1;
    step();
    cfgWe = 1'h0;
    step();
  endtask
  task automatic start(input logic [2:0] s);
    {slotStart, slotIdx} = {1'h1, s};
    step();
    slotStart = 1'h0;
  endtask
  // valid stays up so items go back to back; caller lowers it after the last one
  task automatic rx(input logic [15:0] v, input logic isVal, ok);
    {netRxData, netRxValidator, netRxOk, netRxValid} = {v, isVal, ok, 1'h1};
    for (int i = 0; i < 100 && netRxReady !== 1'h1; i++) step();
    step();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    {hostWe, hostAddr, hostWdata} = {1'h1, a, v};
    step();
    hostWe = 1'h0;
    step();
  endtask
  task automatic rd(input logic [7:0] a);
    hostAddr = a;
    step();
    d = hostRdata;
  endtask

  task automatic t_async_in;
    cfg(3'h0, 5'h00, 4'h0, 1'h0, 1'h0, 8'h10, 8'h02);
    start(3'h0); rx(16'h1234, 1'h0, 1'h1); rx(16'h5555, 1'h0, 1'h0);
    netRxValid = 1'h0;
    step(2);
    chk("busy", 16'h0, busy);
    rd(8'h10); chk("item 10", 16'h1234, d);
    rd(8'h11); chk("item 11", 16'h0000, d);
    start(3'h0); rx(16'h4444, 1'h0, 1'h1); rx(16'h6666, 1'h0, 1'h1);
    netRxValid = 1'h0;
    step(2);
    rd(8'h11); chk("rescan 11", 16'h6666, d);
    $display("test async_in done");
  endtask
  task automatic t_validator;
    wr(8'h20, 16'h00f0); wr(8'h21, 16'h7777);
    cfg(3'h1, 5'h00, 4'h0, 1'h0, 1'h1, 8'h20, 8'h02);
    start(3'h1); rx(16'haaaa, 1'h1, 1'h0); rx(16'hbbbb, 1'h0, 1'h0);
    netRxValid = 1'h0;
    step(2);
    rd(8'h20); chk("validator", 16'h00f1, d);
    rd(8'h21); chk("held item", 16'h7777, d);
    $display("test validator done");
  endtask
  task automatic t_async_out;
    cfg(3'h2, 5'h03, 4'h0, 1'h1, 1'h0, 8'h30, 8'h01); wr(8'h30, 16'habcd);
    start(3'h2);
    chk("busy no scan", 16'h0, busy);
    chk("signif early", 16'h0, outSignificant[2]);
    {scanReq, scanReqSet} = {1'h1, 5'h03};
    step();
    scanReq = 1'h0;
    step(2);
    chk("signif", 16'h1, outSignificant[2]);
    chk("refreshed", 16'h1, outRefreshed[2]);
    start(3'h2);
    for (n = 0; n < 20 && netTxValid !== 1'h1; n++) step();
    step(3);
    chk("tx stalled", 16'h1, netTxValid);
    chk("tx data", 16'habcd, netTxData);
    chk("tx fresh", 16'h1, netTxFresh);
    netTxReady = 1'h1;
    step();
    netTxReady = 1'h0;
    step();
    chk("done", 16'h0, busy);
    step(5 * MS);
    chk("unrefreshed", 16'h0, outRefreshed[2]);
    $display("test async_out done");
  endtask
  task automatic t_sync;
    cfg(3'h3, 5'h05, 4'h5, 1'h0, 1'h0, 8'h40, 8'h01); cfg(3'h4, 5'h05, 4'h5, 1'h1, 1'h0, 8'h50, 8'h01);
    wr(8'h50, 16'h5a5a);
    start(3'h3);
    for (n = 0; n < 200 && netRxReady !== 1'h1; n++) step();
    chk("cons delay", 16'h1, n >= CONS - 1 && n <= CONS + 1);
    rx(16'h4321, 1'h0, 1'h1);
    netRxValid = 1'h0;
    for (n = 0; n < 50 && syncTrigger !== 1'h1; n++) step();
    chk("trigger set", 16'h5, syncTriggerSet);
    step(5);
    chk("sync signif", 16'h1, outSignificant[4]);
    rd(8'h40); chk("sync item", 16'h4321, d);
    netTxReady = 1'h1;
    start(3'h4);
    for (n = 0; n < 300 && netTxValid !== 1'h1; n++) step();
    chk("prod delay", 16'h1, n >= PROD && n <= PROD + 2);
    chk("sync tx", 16'h5a5a, netTxData);
    step(2);
    netTxReady = 1'h0;
    $display("test sync done");
  endtask
  // reset in the middle of a sync delay must drop busy, flags and slot config
  task automatic t_reset_mid;
    start(3'h3);
    step(3);
    chk("pre reset busy", 16'h1, busy);
    rst_n = 1'h0;
    step(2);
    rst_n = 1'h1;
    chk("mid signif", 16'h0, outSignificant);
    chk("mid fresh", 16'h0, outRefreshed);
    chk("mid busy", 16'h0, busy);
    start(3'h3);
    step();
    chk("mid async busy", 16'h0, busy);
    chk("mid no trigger", 16'h0, syncTrigger);
    $display("test reset_mid done");
  endtask

  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    {cfgWe, cfgSync, cfgSource, cfgOutput, cfgHold, hostWe, scanReq, slotStart, netRxValid} = '0;
    {netRxValidator, netRxOk, netTxReady, cfgSlot, slotIdx, cfgScanSet, scanReqSet, cfgSyncSet} = '0;
    {cfgBase, cfgCount, refreshCoef, hostAddr, hostWdata, netRxData} = '0;
    {cfgPeriodMs, refreshOffset} = {8'h01, 8'h02};
    step(6);
    rst_n = 1'h1;
    chk("reset signif", 16'h0, outSignificant);
    chk("reset fresh", 16'h0, outRefreshed);
    $display("test reset done");
    t_async_in();
    t_validator();
    t_async_out();
    t_sync();
    t_reset_mid();
    final_report();
  end

  // the tests need about 260 cycles; 20000 means a hang
  initial begin
    #2000000;
    fails++;
    final_report();
  end
endmodule // io_scan_scheduler_bench
